// ### core/fdp_poll_ctrl.v
// Purpose: host poller for flash embedded program/erase status overlay
// Assumes: software issued the command sequence before starting the poll
// Notes: mode 0 toggle polling, mode 1 completion-invert polling
// Functional notes
// - mask bits 15:8, 4 and 0
// - buffered program: poll last loaded address
// - program suspend gives array data only
// - erase polling address inside erasing sector
// - take valid data from next read
// - completion status only from valid addresses
// - timing flag set: recheck completion bit
// - erase begun flag; confirm busy first (code sets it from bit 3 of every read but the S_DATA read)
// - start toggle polling with two reads
// - toggling with timing flag: recheck, reset
// - resumed polling restarts double read
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "fdp_defines.vh"
module fdp_poll_ctrl #(
	parameter ADDR_W = 26,
	parameter TIMEOUT_DEF = `FDP_TIMEOUT_RESET
) (
	input wire I_SYS_CLK,
	input wire I_SYS_RST,
	input wire [3:0] I_REG_ADDR,
	input wire [31:0] I_REG_WDATA,
	input wire I_REG_WR,
	input wire I_REG_RD,
	output reg [31:0] O_REG_RDATA,
	input wire [15:0] I_FLASH_DQ,
	output reg [ADDR_W-1:0] O_FLASH_ADDR,
	output reg O_FLASH_CE_N,
	output reg O_FLASH_OE_N,
	output reg O_FLASH_WE_N,
	output reg O_FLASH_DQ_OE,
	output reg O_BUSY
);
	localparam S_IDLE = 3'h0;
	localparam S_READ1 = 3'h1;
	localparam S_READ2 = 3'h2;
	localparam S_EVAL = 3'h3;
	localparam S_RECHECK = 3'h4;
	localparam S_FINAL = 3'h5;
	localparam S_DATA = 3'h6;
	localparam S_DRAIN = 3'h7;

	reg [2:0] state_reg;
	reg mode_reg;
	reg [ADDR_W-1:0] addr_reg;
	reg [31:0] timeout_reg;
	reg [31:0] elapsed_reg;
	reg [5:0] status_reg;
	reg [15:0] prev_reg;
	reg [15:0] last_word_reg;
	reg [15:0] exp_data_reg;
	reg rc_start_reg;
	reg timing_seen_reg;
	reg rd_busy_reg;
	wire rc_cs_n;
	wire rc_oe_n;
	wire rc_done;
	wire [15:0] rc_data;

	fdp_read_cycle u_read (
		.clk(I_SYS_CLK),
		.rst(I_SYS_RST),
		.start(rc_start_reg),
		.data_in(I_FLASH_DQ),
		.cs_n(rc_cs_n),
		.oe_n(rc_oe_n),
		.done(rc_done),
		.data_out(rc_data)
	);

	// only the defined polling bits survive, reserved bits never compare
	function [15:0] poll_mask;
		input [15:0] w;
		begin
			poll_mask = w & `FDP_POLL_MASK;
		end
	endfunction

	function toggling;
		input [15:0] a;
		input [15:0] b;
		reg [15:0] d;
		begin
			d = poll_mask(a) ^ poll_mask(b);
			toggling = d[`FDP_BIT_ACTIVITY];
		end
	endfunction

	wire start_wr = I_REG_WR && (I_REG_ADDR == `FDP_REG_CTRL) && I_REG_WDATA[`FDP_CTRL_START];
	wire abort_wr = I_REG_WR && (I_REG_ADDR == `FDP_REG_CTRL) && I_REG_WDATA[`FDP_CTRL_ABORT];
	wire timed_out = (elapsed_reg >= timeout_reg);
	wire dq7_true = (rc_data[`FDP_BIT_COMPLETION] == exp_data_reg[`FDP_BIT_COMPLETION]);

	// a read left running after abort would land in the next poll
	// so its frame is tracked from start request to done
	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			rd_busy_reg <= 1'b0;
		end else if (rc_start_reg) begin
			rd_busy_reg <= 1'b1;
		end else if (rc_done) begin
			rd_busy_reg <= 1'b0;
		end
	end

	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			O_FLASH_CE_N <= 1'b1;
			O_FLASH_OE_N <= 1'b1;
			O_FLASH_WE_N <= 1'b1;
			O_FLASH_DQ_OE <= 1'b0;
		end else begin
			// host never writes here; commands go out through another path
			O_FLASH_CE_N <= rc_cs_n;
			O_FLASH_OE_N <= rc_oe_n;
			O_FLASH_WE_N <= 1'b1;
			O_FLASH_DQ_OE <= 1'b0;
		end
	end

	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			mode_reg <= 1'b0;
			addr_reg <= {ADDR_W{1'b0}};
			timeout_reg <= TIMEOUT_DEF;
			exp_data_reg <= 16'h0000;
			O_REG_RDATA <= 32'h0000_0000;
		end else begin
			if (I_REG_WR && state_reg == S_IDLE) begin
				if (I_REG_ADDR == `FDP_REG_CTRL) begin
					mode_reg <= I_REG_WDATA[`FDP_CTRL_MODE];
				end else if (I_REG_ADDR == `FDP_REG_ADDR) begin
					// software must give last buffered word or erasing sector address
					addr_reg <= I_REG_WDATA[ADDR_W-1:0];
				end else if (I_REG_ADDR == `FDP_REG_TIMEOUT) begin
					timeout_reg <= I_REG_WDATA;
				end else if (I_REG_ADDR == `FDP_REG_EXP_DATA) begin
					exp_data_reg <= I_REG_WDATA[15:0];
				end
			end
			if (I_REG_RD) begin
				if (I_REG_ADDR == `FDP_REG_CTRL) begin
					O_REG_RDATA <= {30'h0, mode_reg, 1'b0};
				end else if (I_REG_ADDR == `FDP_REG_ADDR) begin
					O_REG_RDATA <= {{(32-ADDR_W){1'b0}}, addr_reg};
				end else if (I_REG_ADDR == `FDP_REG_STATUS) begin
					O_REG_RDATA <= {26'h0, status_reg};
				end else if (I_REG_ADDR == `FDP_REG_TIMEOUT) begin
					O_REG_RDATA <= timeout_reg;
				end else if (I_REG_ADDR == `FDP_REG_LAST_WORD) begin
					O_REG_RDATA <= {16'h0, last_word_reg};
				end else if (I_REG_ADDR == `FDP_REG_EXP_DATA) begin
					O_REG_RDATA <= {16'h0, exp_data_reg};
				end else begin
					O_REG_RDATA <= 32'h0000_0000;
				end
			end
		end
	end

	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			state_reg <= S_IDLE;
			status_reg <= 6'h00;
			prev_reg <= 16'h0000;
			last_word_reg <= 16'h0000;
			elapsed_reg <= 32'h0000_0000;
			rc_start_reg <= 1'b0;
			timing_seen_reg <= 1'b0;
			O_FLASH_ADDR <= {ADDR_W{1'b0}};
			O_BUSY <= 1'b0;
		end else begin
			rc_start_reg <= 1'b0;
			if (state_reg != S_IDLE) begin
				elapsed_reg <= elapsed_reg + 32'h1;
			end
			if (rc_done) begin
				last_word_reg <= rc_data;
				if (rc_data[`FDP_BIT_ERASE_BEGUN] && state_reg != S_DATA) begin
					status_reg[`FDP_ST_ERASE_BEGUN] <= 1'b1;
				end
			end
			if (abort_wr && state_reg != S_IDLE) begin
				// leaving mid-poll drops history, next start redoes double read
				status_reg[`FDP_ST_BUSY] <= 1'b0;
				if (rc_start_reg || (rd_busy_reg && !rc_done)) begin
					// let the open read frame close before going idle
					state_reg <= S_DRAIN;
				end else begin
					state_reg <= S_IDLE;
					O_BUSY <= 1'b0;
				end
			end else begin
				case (state_reg)
				S_IDLE: begin
					if (start_wr) begin
						state_reg <= S_READ1;
						status_reg <= 6'h01;
						elapsed_reg <= 32'h0000_0000;
						timing_seen_reg <= 1'b0;
						O_FLASH_ADDR <= addr_reg;
						rc_start_reg <= 1'b1;
						O_BUSY <= 1'b1;
					end
				end
				S_READ1: begin
					if (rc_done) begin
						prev_reg <= rc_data;
						if (mode_reg) begin
							state_reg <= S_EVAL;
						end else begin
							state_reg <= S_READ2;
							rc_start_reg <= 1'b1;
						end
					end
				end
				S_READ2: begin
					if (rc_done) begin
						state_reg <= S_EVAL;
					end
				end
				S_EVAL: begin
					if (mode_reg ? dq7_true : !toggling(prev_reg, rc_data)) begin
						// next read gives real array data, bits may lag dq7
						state_reg <= S_FINAL;
						rc_start_reg <= 1'b1;
					end else if (rc_data[`FDP_BIT_TIMING] || timing_seen_reg) begin
						timing_seen_reg <= 1'b1;
						state_reg <= S_RECHECK;
						prev_reg <= rc_data;
						rc_start_reg <= 1'b1;
					end else if (timed_out) begin
						// protected-sector busy ends by itself, timeout covers stalls
						status_reg <= 6'h18;
						state_reg <= S_IDLE;
						O_BUSY <= 1'b0;
					end else begin
						prev_reg <= rc_data;
						state_reg <= mode_reg ? S_READ1 : S_READ2;
						rc_start_reg <= 1'b1;
					end
				end
				S_RECHECK: begin
					if (rc_done) begin
						if (mode_reg ? dq7_true : !toggling(prev_reg, rc_data)) begin
							state_reg <= S_FINAL;
							rc_start_reg <= 1'b1;
						end else begin
							status_reg <= 6'h14;
							state_reg <= S_IDLE;
							O_BUSY <= 1'b0;
						end
					end
				end
				S_FINAL: begin
					state_reg <= S_DATA;
				end
				S_DATA: begin
					if (rc_done) begin
						// array data read back; suspend yields array data only
						status_reg[`FDP_ST_DONE] <= 1'b1;
						status_reg[`FDP_ST_BUSY] <= 1'b0;
						state_reg <= S_IDLE;
						O_BUSY <= 1'b0;
					end
				end
				S_DRAIN: begin
					// hold busy until chip select is released
					if (rc_done) begin
						status_reg[`FDP_ST_BUSY] <= 1'b0;
						state_reg <= S_IDLE;
						O_BUSY <= 1'b0;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### core/fdp_defines.vh
// Purpose: constants for the flash data polling host controller
// Assumes: 25 MHz system clock, 16-bit flash data bus
// Notes: offsets are word addresses on the software port
`ifndef FDP_DEFINES_VH
`define FDP_DEFINES_VH
`define FDP_REG_CTRL 4'h0
`define FDP_REG_ADDR 4'h1
`define FDP_REG_STATUS 4'h2
`define FDP_REG_TIMEOUT 4'h3
`define FDP_REG_LAST_WORD 4'h4
`define FDP_REG_EXP_DATA 4'h5
`define FDP_CTRL_START 0
`define FDP_CTRL_MODE 1
`define FDP_CTRL_ABORT 2
`define FDP_BIT_COMPLETION 7
`define FDP_BIT_ACTIVITY 6
`define FDP_BIT_TIMING 5
`define FDP_BIT_ERASE_BEGUN 3
`define FDP_BIT_SECTOR_TGL 2
`define FDP_POLL_MASK 16'h00EC
`define FDP_ST_BUSY 0
`define FDP_ST_DONE 1
`define FDP_ST_FAIL 2
`define FDP_ST_TIMEOUT 3
`define FDP_ST_NEED_RESET 4
`define FDP_ST_ERASE_BEGUN 5
`define FDP_CYC_PER_READ 4'h4
`define FDP_TIMEOUT_RESET 32'h0001_0000
`define FDP_BUS_CYC_NS 40
`define FDP_RD_STROBE_NS 120
`define FDP_RD_STROBE_CYC ((`FDP_RD_STROBE_NS + `FDP_BUS_CYC_NS - 1) / `FDP_BUS_CYC_NS)
`endif

// ### core/fdp_read_cycle.v
// Purpose: one flash read cycle framed by chip select and output enable
// Assumes: flash data lines sampled through two flops before use
// Notes: data captured at the end of the strobe window
`timescale 1ns/1ps
`default_nettype none
`include "fdp_defines.vh"
module fdp_read_cycle #(
	parameter STROBE_CYC = `FDP_RD_STROBE_CYC
) (
	input wire clk,
	input wire rst,
	input wire start,
	input wire [15:0] data_in,
	output reg cs_n,
	output reg oe_n,
	output reg done,
	output reg [15:0] data_out
);
	reg [15:0] sync1_reg;
	reg [15:0] sync2_reg;
	reg [7:0] cnt_reg;
	reg busy_reg;
	always @(posedge clk) begin
		sync1_reg <= data_in;
		sync2_reg <= sync1_reg;
	end
	// two sync stages added to strobe window so sampled data is settled
	always @(posedge clk) begin
		if (rst) begin
			cs_n <= 1'b1;
			oe_n <= 1'b1;
			done <= 1'b0;
			data_out <= 16'h0000;
			cnt_reg <= 8'h00;
			busy_reg <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy_reg) begin
				if (start) begin
					busy_reg <= 1'b1;
					cs_n <= 1'b0;
					oe_n <= 1'b0;
					cnt_reg <= 8'h00;
				end
			end else if (cnt_reg == STROBE_CYC[7:0] + 8'h02) begin
				// every read is a fresh oe/cs frame so toggle bits advance
				data_out <= sync2_reg;
				cs_n <= 1'b1;
				oe_n <= 1'b1;
				busy_reg <= 1'b0;
				done <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### verification/fdp_flash_model.sv
// Purpose: flash status overlay model
// Assumes: a read is framed by ce_n and oe_n both low
// Notes: a released bus shows the inverse word
`timescale 1ns/1ps
`default_nettype none
module fdp_flash_model (
	input wire logic i_rd_n,
	input wire logic i_arm,
	input wire logic i_erase,
	input wire logic i_in_sector,
	input wire logic i_fail,
	input wire logic [7:0] i_reads,
	input wire logic [15:0] i_word,
	output logic [15:0] o_dq
);
	logic [7:0] cnt = 8'h00;
	logic tgl = 1'b0;
	logic [7:0] junk = 8'h5A;
	logic [15:0] w = 16'h0000;
	always @(posedge i_arm) cnt = i_reads;
	// reserved bits move on every status read to catch unmasked compares
	always @(negedge i_rd_n) begin
		junk = junk + 8'h3B;
		if (cnt != 8'h00 || i_fail) begin
			tgl = ~tgl;
			w = {junk, i_erase ? 1'b0 : ~i_word[7], tgl, i_fail, junk[0], i_erase,
				i_erase & i_in_sector & tgl, 1'b0, junk[1]};
			if (!i_fail) cnt = cnt - 8'h01;
		end else
			w = i_word;
	end
	assign o_dq = i_rd_n ? ~w : w;
endmodule
`default_nettype wire

// ### verification/fdp_poll_ctrl_assertions.sv
// Purpose: port checks of the poll host
// Assumes: one clock, sync reset
// Notes: strobe length fixed by the read cycle
`timescale 1ns/1ps
`default_nettype none
module fdp_poll_assertions #(
	parameter ADDR_W = 26,
	parameter TIMEOUT_DEF = 32'h0001_0000
) (
	input wire logic I_SYS_CLK,
	input wire logic I_SYS_RST,
	input wire logic [3:0] I_REG_ADDR,
	input wire logic [31:0] I_REG_WDATA,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [31:0] O_REG_RDATA,
	input wire logic [15:0] I_FLASH_DQ,
	input wire logic [ADDR_W-1:0] O_FLASH_ADDR,
	input wire logic O_FLASH_CE_N,
	input wire logic O_FLASH_OE_N,
	input wire logic O_FLASH_WE_N,
	input wire logic O_FLASH_DQ_OE,
	input wire logic O_BUSY
);
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_SYS_RST);
	logic [31:0] busy_cnt;
	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST || !O_BUSY)
			busy_cnt <= 32'h0;
		else
			busy_cnt <= busy_cnt + 32'h1;
	end
	sequence s_start;
		I_REG_WR && I_REG_ADDR == 4'h0 && I_REG_WDATA[0] && !O_BUSY;
	endsequence
	sequence s_first;
		##[1:6] $fell(O_FLASH_CE_N);
	endsequence
	sequence s_strobe;
		(!O_FLASH_OE_N)[*6] ##1 O_FLASH_OE_N;
	endsequence
	chk_no_flash_wr: assert property (O_FLASH_WE_N && !O_FLASH_DQ_OE)
		else $error("flash write seen");
	chk_ce_oe_pair: assert property (O_FLASH_CE_N == O_FLASH_OE_N)
		else $error("ce and oe differ");
	chk_addr_hold: assert property (O_BUSY && $past(O_BUSY) |-> $stable(O_FLASH_ADDR))
		else $error("address moved in poll");
	chk_strobe_len: assert property ($fell(O_FLASH_OE_N) |-> s_strobe)
		else $error("read strobe length wrong");
	chk_start_read: assert property (s_start |-> s_first)
		else $error("no read after start");
	chk_done_idle: assert property ($fell(O_BUSY) |-> O_FLASH_CE_N)
		else $error("done inside a read");
	chk_unmapped_zero: assert property (I_REG_RD && I_REG_ADDR > 4'h5 |=> O_REG_RDATA == 32'h0)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!$past(I_REG_RD) |-> $stable(O_REG_RDATA))
		else $error("read data changed");
	chk_busy_bound: assert property (busy_cnt <= TIMEOUT_DEF + 32'h20)
		else $error("poll ran past timeout");
endmodule
bind fdp_poll_ctrl fdp_poll_assertions #(.ADDR_W(ADDR_W), .TIMEOUT_DEF(TIMEOUT_DEF)) fdp_poll_assertions_inst (
	.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
	.I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA), .I_FLASH_DQ(I_FLASH_DQ),
	.O_FLASH_ADDR(O_FLASH_ADDR), .O_FLASH_CE_N(O_FLASH_CE_N), .O_FLASH_OE_N(O_FLASH_OE_N),
	.O_FLASH_WE_N(O_FLASH_WE_N), .O_FLASH_DQ_OE(O_FLASH_DQ_OE), .O_BUSY(O_BUSY));
`default_nettype wire

// ### verification/test_fdp_poll_ctrl.sv
// Purpose: bench for the flash poll host
// Assumes: 25 MHz clock
// Notes: model stays busy for a set read count
`timescale 1ns/1ps
`default_nettype none
module test_fdp_poll_ctrl;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] ra = 4'h0;
	logic [31:0] wd = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic arm = 1'b0;
	logic er = 1'b0;
	logic fl = 1'b0;
	logic [7:0] nr = 8'h00;
	logic [15:0] aw = 16'h0000;
	wire [31:0] rdat;
	wire [15:0] dq;
	wire [25:0] fa;
	wire ce_n, oe_n, we_n, dq_oe, busy;
	int miscompares = 0;
	int check_count = 0;
	always #20 clk = ~clk;
	fdp_poll_ctrl #(.ADDR_W(26)) fdp_poll_ctrl_inst (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_REG_ADDR(ra),
		.I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdat), .I_FLASH_DQ(dq), .O_FLASH_ADDR(fa),
		.O_FLASH_CE_N(ce_n), .O_FLASH_OE_N(oe_n), .O_FLASH_WE_N(we_n), .O_FLASH_DQ_OE(dq_oe), .O_BUSY(busy));
	fdp_flash_model fdp_flash_model_inst (.i_rd_n(ce_n | oe_n), .i_arm(arm), .i_erase(er), .i_fail(fl),
		.i_in_sector(fa[25:8] == 18'h00001),
		.i_reads(nr), .i_word(aw), .o_dq(dq));
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, e, rdat & m);
	endtask
	task automatic wait_idle;
		int i = 0;
		while (busy !== 1'b0 && i < 5000) begin
			@(posedge clk);
			i++;
		end
		chk("idle", 32'h0, {31'h0, busy});
	endtask
	// arm only after the counts settle, so the model never sees stale ones
	task automatic run(input logic m, e, f, input logic [7:0] n, input logic [15:0] w, input logic [31:0] x);
		er <= e;
		fl <= f;
		nr <= n;
		aw <= w;
		wreg(4'h5, x);
		arm <= 1'b1;
		wreg(4'h1, 32'h100);
		arm <= 1'b0;
		wreg(4'h0, {30'h0, m, 1'b1});
		repeat (2) @(posedge clk);
	endtask
	task automatic t_reset;
		chk("pins", 32'hC, {28'h0, we_n, ce_n, dq_oe, busy});
		rreg(4'h3, 32'hFFFFFFFF, 32'h10000, "timeout");
		rreg(4'h2, 32'hFFFFFFFF, 32'h0, "status");
		rreg(4'hF, 32'hFFFFFFFF, 32'h0, "unmapped");
	endtask
	task automatic t_toggle;
		run(1'b0, 1'b0, 1'b0, 8'h05, 16'h1234, 32'h0);
		wreg(4'h3, 32'h40);
		wait_idle();
		chk("addr", 32'h100, {6'h0, fa});
		rreg(4'h2, 32'h1F, 32'h2, "status");
		rreg(4'h4, 32'hFFFF, 32'h1234, "last");
		rreg(4'h3, 32'hFFFFFFFF, 32'h10000, "timeout");
	endtask
	task automatic t_fails;
		run(1'b0, 1'b0, 1'b1, 8'h01, 16'h1234, 32'h0);
		wait_idle();
		rreg(4'h2, 32'h1F, 32'h14, "status");
		run(1'b1, 1'b1, 1'b1, 8'h01, 16'hFFFF, 32'h80);
		wait_idle();
		rreg(4'h2, 32'h1F, 32'h14, "status");
	endtask
	task automatic t_complete;
		run(1'b1, 1'b1, 1'b0, 8'h04, 16'hFFFF, 32'h80);
		wait_idle();
		rreg(4'h2, 32'h3F, 32'h22, "status");
		run(1'b1, 1'b0, 1'b0, 8'h03, 16'h00A5, 32'hA5);
		wait_idle();
		rreg(4'h4, 32'hFFFF, 32'h00A5, "last");
	endtask
	task automatic t_timeout;
		wreg(4'h3, 32'h40);
		run(1'b0, 1'b0, 1'b0, 8'hFF, 16'h1234, 32'h0);
		wait_idle();
		rreg(4'h2, 32'h1F, 32'h18, "status");
		wreg(4'h3, 32'h10000);
		run(1'b0, 1'b0, 1'b0, 8'h02, 16'h1234, 32'h0);
		wait_idle();
		rreg(4'h2, 32'h1F, 32'h2, "status");
	endtask
	// abort in mid-read must close the frame, then a fresh start completes
	task automatic t_abort;
		run(1'b0, 1'b0, 1'b0, 8'hFF, 16'h1234, 32'h0);
		repeat (3) @(posedge clk);
		wreg(4'h0, 32'h4);
		wait_idle();
		chk("drain", 32'h1, {31'h0, ce_n});
		rreg(4'h2, 32'h1F, 32'h0, "status");
		run(1'b0, 1'b0, 1'b0, 8'h02, 16'h1234, 32'h0);
		wait_idle();
		rreg(4'h2, 32'h1F, 32'h2, "status");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_toggle();
		t_fails();
		t_complete();
		t_timeout();
		t_abort();
		report_and_stop();
	end
	initial begin
		#2000000;
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire
